/* File: common/jtag_scan_pkg.sv */
// shared constants, types and state encoding for the test access block
package jtag_scan_pkg;

	// instruction register and opcodes
	localparam int IR_W = 4;
	localparam logic [3:0] OP_EXTEST = 4'h0;
	localparam logic [3:0] OP_IDCODE = 4'h1;
	localparam logic [3:0] OP_SAMPLE = 4'h2;
	localparam logic [3:0] OP_CORE_RESET = 4'hc;
	localparam logic [3:0] OP_MAILBOX = 4'hd;
	localparam logic [3:0] OP_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// identification register layout
	localparam int ID_W = 32;
	localparam int ID_REV_LSB = 28;
	localparam int ID_REV_W = 4;
	localparam int ID_PART_LSB = 12;
	localparam int ID_PART_W = 16;
	localparam int ID_MFR_LSB = 1;
	localparam int ID_MFR_W = 11;
	localparam logic ID_MARKER = 1'b1;

	// debugger view of the mailbox scan register
	localparam int MBOX_DR_W = 10;
	localparam int MBOX_READY_BIT = 8;
	localparam int MBOX_ACCESS_BIT = 9;

	// cpu i/o space
	localparam int IO_ADDR_W = 6;
	localparam logic [5:0] MBOX_IO_ADDR = 6'h31;
	localparam logic [7:0] MBOX_RESET = 8'h00;
	localparam logic [7:0] IO_RESET = 8'h00;
	localparam logic [7:0] IO_UNMAPPED = 8'h00;

	// start-up time-out after reset release
	localparam int CLK_HZ = 20_000_000;
	localparam int STARTUP_SHORT_US = 64;
	localparam int STARTUP_LONG_MS = 65;
	localparam int STARTUP_SHORT_CYC = STARTUP_SHORT_US * (CLK_HZ / 1_000_000);
	localparam int STARTUP_LONG_CYC = STARTUP_LONG_MS * (CLK_HZ / 1_000);
	localparam int TMO_W = 21;

	// tap pins and cpu i/o request travel together
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} tap_pins_t;

	typedef struct packed {
		logic [5:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} io_req_t;

	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} tap_state_t;

endpackage : jtag_scan_pkg

/* File: logic/sync_2ff.sv */
// two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : sync_2ff
`default_nettype wire

/* File: logic/byte_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q, rd_ptr_q;
	logic [AW:0] count_q;
	logic push, pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem_q[rd_ptr_q];

	// storage
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	// pointers, count and registered flags
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
			in_ready_out <= (count_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
			out_valid_out <= (count_q + (AW+1)'(push) - (AW+1)'(pop)) != '0;
		end
	end
endmodule : byte_fifo
`default_nettype wire

/* File: logic/jtag_scan_top.sv */
// tap controller, data registers, reset register and cpu debug mailbox
`timescale 1ns/10ps
`default_nettype none
module jtag_scan_top
	import jtag_scan_pkg::*;
#(
	parameter int NUM_PINS = 8,
	parameter int FIFO_DEPTH = 16,
	parameter int STARTUP_LONG = STARTUP_LONG_CYC,
	parameter logic [3:0] ID_REVISION = 4'h7, // arbitrary value
	parameter logic [15:0] ID_PART = 16'h5a3c, // arbitrary value
	parameter logic [10:0] ID_MAKER = 11'h2a6 // arbitrary value
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// tap pins and external reset pin
	input wire tap_pins_t tap_in,
	output logic tdo_out,
	output logic tdo_oe_n_out,
	input wire logic ext_reset_n_in,
	// fuses, lock bits and control bits
	input wire logic tap_enable_fuse_in,
	input wire logic tap_disable_bit_in,
	input wire logic clock_option_fuse_in,
	input wire logic lock_bit_one_in,
	input wire logic lock_bit_two_in,
	input wire logic fuse_program_req_in,
	input wire logic chip_erase_in,
	output logic debug_enable_fuse_out,
	// cpu i/o port
	input wire io_req_t io_in,
	output logic [7:0] io_rdata_out,
	output logic mbox_ready_out,
	// port pins
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe_n_out,
	input wire logic [NUM_PINS-1:0] core_pin_out_in,
	input wire logic [NUM_PINS-1:0] core_pin_dir_in,
	output logic core_reset_out
);
	localparam int BSC_W = 3 * NUM_PINS;
	localparam int SYNC_W = 4 + NUM_PINS;
	localparam logic [TMO_W-1:0] TMO_SHORT = TMO_W'(STARTUP_SHORT_CYC);
	localparam logic [TMO_W-1:0] TMO_LONG = TMO_W'(STARTUP_LONG);

	logic [SYNC_W-1:0] sync_v;
	logic tck_s, tms_s, tdi_s, ext_rst_n_s;
	logic [NUM_PINS-1:0] pin_s;
	logic tck_prev_q, tck_rise, tck_fall;
	logic tap_on;
	tap_state_t state_q, state_d;
	logic [IR_W-1:0] ir_q, ir_shift_q;
	logic bypass_q, rst_bit_q;
	logic [ID_W-1:0] id_shift_q, id_value;
	logic [BSC_W-1:0] bsc_shift_q, bsc_upd_q, bsc_capture;
	logic [MBOX_DR_W-1:0] mbox_shift_q;
	logic [7:0] mbox_q, io_plain_q;
	logic ready_flag_q, dbg_access_q, debug_fuse_q, erased_q;
	logic mbox_sel, mbox_wr, mbox_clr;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic reset_src;
	logic [TMO_W-1:0] tmo_q;
	logic dr_out;
	logic is_bsc;

	// every pin-side input crosses into clk_in before use
	sync_2ff #(.W(SYNC_W)) u_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.async_in({tap_in.tck, tap_in.tms, tap_in.tdi, ext_reset_n_in, pin_in}),
		.sync_out(sync_v)
	);
	assign {tck_s, tms_s, tdi_s, ext_rst_n_s, pin_s} = sync_v;

	// test clock edges found by the core clock; tck must stay below clk_in/4
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tck_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= tck_s;
		end
	end
	assign tck_rise = tck_s && !tck_prev_q;
	assign tck_fall = !tck_s && tck_prev_q;
	assign tap_on = tap_enable_fuse_in && !tap_disable_bit_in;

	// tap controller next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			TLR: state_d = tms_s ? TLR : RTI;
			RTI: state_d = tms_s ? SEL_DR : RTI;
			SEL_DR: state_d = tms_s ? SEL_IR : CAP_DR;
			CAP_DR: state_d = tms_s ? EX1_DR : SH_DR;
			SH_DR: state_d = tms_s ? EX1_DR : SH_DR;
			EX1_DR: state_d = tms_s ? UPD_DR : PAU_DR;
			PAU_DR: state_d = tms_s ? EX2_DR : PAU_DR;
			EX2_DR: state_d = tms_s ? UPD_DR : SH_DR;
			UPD_DR: state_d = tms_s ? SEL_DR : RTI;
			SEL_IR: state_d = tms_s ? TLR : CAP_IR;
			CAP_IR: state_d = tms_s ? EX1_IR : SH_IR;
			SH_IR: state_d = tms_s ? EX1_IR : SH_IR;
			EX1_IR: state_d = tms_s ? UPD_IR : PAU_IR;
			PAU_IR: state_d = tms_s ? EX2_IR : PAU_IR;
			EX2_IR: state_d = tms_s ? UPD_IR : SH_IR;
			UPD_IR: state_d = tms_s ? SEL_DR : RTI;
		endcase
	end

	// tap state; a disabled port is parked in test-logic-reset
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= TLR;
		end else if (!tap_on) begin
			state_q <= TLR;
		end else if (tck_rise) begin
			state_q <= state_d;
		end
	end

	// instruction register, lsb shifted first, default idcode
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ir_q <= OP_IDCODE;
			ir_shift_q <= IR_CAPTURE;
		end else if (state_q == TLR) begin
			ir_q <= OP_IDCODE;
		end else if (tck_rise) begin
			unique case (state_q)
				CAP_IR: ir_shift_q <= IR_CAPTURE;
				SH_IR: ir_shift_q <= {tdi_s, ir_shift_q[IR_W-1:1]};
				UPD_IR: ir_q <= ir_shift_q;
				default: ;
			endcase
		end
	end

	// identification word; its fields are fixed by parameters
	assign id_value[ID_REV_LSB +: ID_REV_W] = ID_REVISION;
	assign id_value[ID_PART_LSB +: ID_PART_W] = ID_PART;
	assign id_value[ID_MFR_LSB +: ID_MFR_W] = ID_MAKER;
	assign id_value[0] = ID_MARKER;

	// capture of pins: input cell, core output value, core direction
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_cap
			assign bsc_capture[3*i] = pin_s[i];
			assign bsc_capture[3*i+1] = core_pin_out_in[i];
			assign bsc_capture[3*i+2] = core_pin_dir_in[i];
		end
	endgenerate
	assign is_bsc = (ir_q == OP_EXTEST) || (ir_q == OP_SAMPLE);

	// bypass and identification shift stages
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bypass_q <= 1'b0;
			id_shift_q <= '0;
		end else if (tck_rise && state_q == CAP_DR) begin
			bypass_q <= 1'b0;
			id_shift_q <= id_value;
		end else if (tck_rise && state_q == SH_DR) begin
			bypass_q <= tdi_s;
			id_shift_q <= {tdi_s, id_shift_q[ID_W-1:1]};
		end
	end

	// boundary chain; sampling never touches the pins themselves
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bsc_shift_q <= '0;
			bsc_upd_q <= '0;
		end else if (tck_rise && is_bsc) begin
			unique case (state_q)
				CAP_DR: bsc_shift_q <= bsc_capture;
				SH_DR: bsc_shift_q <= {tdi_s, bsc_shift_q[BSC_W-1:1]};
				UPD_DR: bsc_upd_q <= bsc_shift_q;
				default: ;
			endcase
		end
	end

	// reset bit drives reset straight from the shift stage, no update latch
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_bit_q <= 1'b0;
		end else if (state_q == TLR) begin
			rst_bit_q <= 1'b0;
		end else if (tck_rise && state_q == SH_DR && ir_q == OP_CORE_RESET) begin
			rst_bit_q <= tdi_s;
		end
	end

	// debugger side of the mailbox: capture head byte and flag, update with the ready bit set clears
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mbox_shift_q <= '0;
		end else if (tck_rise && ir_q == OP_MAILBOX) begin
			unique case (state_q)
				CAP_DR: mbox_shift_q <= {dbg_access_q, ready_flag_q, fifo_out_data};
				SH_DR: mbox_shift_q <= {tdi_s, mbox_shift_q[MBOX_DR_W-1:1]};
				default: ;
			endcase
		end
	end
	assign mbox_clr = tck_rise && state_q == UPD_DR && ir_q == OP_MAILBOX
		&& mbox_shift_q[MBOX_READY_BIT];

	// debugger grants cpu access to the shared location
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dbg_access_q <= 1'b0;
		end else if (tck_rise && state_q == UPD_DR && ir_q == OP_MAILBOX) begin
			dbg_access_q <= mbox_shift_q[MBOX_ACCESS_BIT];
		end
	end

	// scan output selected by the active instruction; bypass otherwise
	always_comb begin
		unique case (ir_q)
			OP_EXTEST, OP_SAMPLE: dr_out = bsc_shift_q[0];
			OP_IDCODE: dr_out = id_shift_q[0];
			OP_CORE_RESET: dr_out = rst_bit_q;
			OP_MAILBOX: dr_out = mbox_shift_q[0];
			default: dr_out = bypass_q;
		endcase
	end

	// tdo changes on the falling test clock, driven only while shifting
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tdo_out <= 1'b0;
			tdo_oe_n_out <= 1'b1;
		end else if (tck_fall) begin
			tdo_out <= (state_q == SH_IR) ? ir_shift_q[0] : dr_out;
			tdo_oe_n_out <= !(state_q == SH_IR || state_q == SH_DR);
		end else if (state_q == TLR) begin
			tdo_oe_n_out <= 1'b1;
		end
	end

	// debug fuse: refused while locked unless an erase came first
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			debug_fuse_q <= 1'b0;
			erased_q <= 1'b0;
		end else begin
			if (chip_erase_in) begin
				erased_q <= 1'b1;
				debug_fuse_q <= 1'b0;
			end else if (fuse_program_req_in
				&& (erased_q || !(lock_bit_one_in || lock_bit_two_in))) begin
				debug_fuse_q <= 1'b1;
			end
		end
	end
	assign debug_enable_fuse_out = debug_fuse_q;

	// cpu decode: shared location goes to mailbox only when enabled
	assign mbox_sel = debug_fuse_q && dbg_access_q;
	assign mbox_wr = io_in.wr && io_in.addr == MBOX_IO_ADDR && mbox_sel && mbox_ready_out;

	// cpu-written byte is also queued, up to FIFO_DEPTH bytes; writes while the queue is full are dropped
	byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.in_valid_in(mbox_wr),
		.in_ready_out(mbox_ready_out),
		.in_data_in(io_in.wdata),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(mbox_clr),
		.out_data_out(fifo_out_data)
	);

	// mailbox, ready flag (set wins over clear) and plain i/o register
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mbox_q <= MBOX_RESET;
			io_plain_q <= IO_RESET;
			ready_flag_q <= 1'b0;
		end else begin
			if (mbox_wr) begin
				mbox_q <= io_in.wdata;
				ready_flag_q <= 1'b1;
			end else if (mbox_clr) begin
				ready_flag_q <= 1'b0;
			end
			if (io_in.wr && io_in.addr == MBOX_IO_ADDR && !mbox_sel) begin
				io_plain_q <= io_in.wdata;
			end
		end
	end

	// registered read data, one cycle after the read strobe
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			io_rdata_out <= IO_UNMAPPED;
		end else if (io_in.rd) begin
			if (io_in.addr != MBOX_IO_ADDR) begin
				io_rdata_out <= IO_UNMAPPED;
			end else if (mbox_sel) begin
				io_rdata_out <= {ready_flag_q, mbox_q[6:0]};
			end else begin
				io_rdata_out <= io_plain_q;
			end
		end
	end

	// reset sources and start-up time-out
	assign reset_src = !ext_rst_n_s || rst_bit_q;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tmo_q <= TMO_SHORT;
			core_reset_out <= 1'b1;
		end else if (reset_src) begin
			tmo_q <= clock_option_fuse_in ? TMO_LONG : TMO_SHORT;
			core_reset_out <= 1'b1;
		end else if (tmo_q != '0) begin
			tmo_q <= tmo_q - 1'b1;
			core_reset_out <= 1'b1;
		end else begin
			core_reset_out <= 1'b0;
		end
	end

	// pin drivers: extest first, then reset tristate, then the core
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
			always_ff @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					pin_out[i] <= 1'b0;
					pin_oe_n_out[i] <= 1'b1;
				end else if (ir_q == OP_EXTEST && tap_on) begin
					pin_out[i] <= bsc_upd_q[3*i+1];
					pin_oe_n_out[i] <= !bsc_upd_q[3*i+2];
				end else if (reset_src || core_reset_out) begin
					pin_out[i] <= 1'b0;
					pin_oe_n_out[i] <= 1'b1;
				end else begin
					pin_out[i] <= core_pin_out_in[i];
					pin_oe_n_out[i] <= !core_pin_dir_in[i];
				end
			end
		end
	endgenerate

	// fifo valid goes unused; the head is popped by the same update that clears the flag
	logic unused_fifo_valid;
	assign unused_fifo_valid = fifo_out_valid;
endmodule : jtag_scan_top
`default_nettype wire

/* File: test/jtag_host_model.sv */
// behavioural tester that drives the test pins with its own slow clock
`timescale 1ns/10ps
`default_nettype none
module jtag_host_model
	import jtag_scan_pkg::*;
(
	// test pins toward the device
	output var tap_pins_t tap_out,
	input wire logic tdo_in
);
	// tck rests low between frames
	initial tap_out = '0;

	// one 400 ns tck period, edges kept off the core clock edges
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tap_out.tms = tms;
		tap_out.tdi = tdi;
		#187;
		tdo = tdo_in;
		tap_out.tck = 1'b1;
		#213;
		tap_out.tck = 1'b0;
	endtask : step

	// five tms highs reach test-logic-reset, then park in idle
	task automatic reset_tap();
		logic t;
		#7;
		repeat (5) step(1'b1, 1'b0, t);
		step(1'b0, 1'b0, t);
	endtask : reset_tap

	// idle to shift, n bits, back to idle; ir picks the instruction path
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic t;
		#7;
		dout = '0;
		step(1'b1, 1'b0, t);
		if (ir) begin
			step(1'b1, 1'b0, t);
		end
		step(1'b0, 1'b0, t);
		step(1'b0, 1'b0, t);
		// lsb goes first both ways
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], t);
			dout[i] = t;
		end
		step(1'b1, 1'b0, t);
		// released data line shows the inverse, not the last value
		step(1'b0, ~din[n-1], t);
	endtask : scan
endmodule : jtag_host_model
`default_nettype wire

/* File: test/jtag_scan_chk.sv */
// port-level assertions for the test access block
`timescale 1ns/10ps
`default_nettype none
module jtag_scan_chk
	import jtag_scan_pkg::*;
#(
	parameter int STARTUP_LONG = STARTUP_LONG_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// watched ports
	input wire logic tdo_oe_n_out,
	input wire logic ext_reset_n_in,
	input wire logic tap_enable_fuse_in,
	input wire logic tap_disable_bit_in,
	input wire logic clock_option_fuse_in,
	input wire logic lock_bit_one_in,
	input wire logic lock_bit_two_in,
	input wire logic fuse_program_req_in,
	input wire logic chip_erase_in,
	input wire logic debug_enable_fuse_out,
	input wire io_req_t io_in,
	input wire logic [7:0] io_rdata_out,
	input wire logic core_reset_out
);
	logic erased_q;
	logic [20:0] held_q;

	// an erase lifts the lock refusal for good
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			erased_q <= 1'b0;
		end else if (chip_erase_in) begin
			erased_q <= 1'b1;
		end
	end

	// run length of core reset, saturating; lower bound only, so small slack
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			held_q <= 21'h0;
		end else begin
			held_q <= core_reset_out ? held_q + 21'(held_q != '1) : 21'h0;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	property p_tap_off_quiet;
		(!tap_enable_fuse_in || tap_disable_bit_in) [*4] |-> tdo_oe_n_out;
	endproperty
	a_tap_off_quiet: assert property (p_tap_off_quiet) else $error("tdo driven, tap off");
	property p_tdo_needs_tap;
		$fell(tdo_oe_n_out) |-> $past(tap_enable_fuse_in) && !$past(tap_disable_bit_in);
	endproperty
	a_tdo_needs_tap: assert property (p_tdo_needs_tap) else $error("shift while tap off");
	property p_fuse_lock;
		$rose(debug_enable_fuse_out) |->
			erased_q || (!$past(lock_bit_one_in) && !$past(lock_bit_two_in));
	endproperty
	a_fuse_lock: assert property (p_fuse_lock) else $error("fuse set under lock");
	property p_fuse_req;
		$rose(debug_enable_fuse_out) |-> $past(fuse_program_req_in);
	endproperty
	a_fuse_req: assert property (p_fuse_req) else $error("fuse set without request");
	property p_erase_clears;
		chip_erase_in |=> !debug_enable_fuse_out;
	endproperty
	a_erase_clears: assert property (p_erase_clears) else $error("fuse kept by erase");
	property p_rdata_stands;
		!$past(io_in.rd) && !$past(io_in.rd, 2) |-> $stable(io_rdata_out);
	endproperty
	a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
	property p_unmapped;
		io_in.rd && io_in.addr != MBOX_IO_ADDR |-> ##[1:2] io_rdata_out == IO_UNMAPPED;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_pin_reset;
		!ext_reset_n_in [*5] |-> core_reset_out;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");
	property p_startup;
		$fell(core_reset_out) |->
			held_q + 21'h2 >= (clock_option_fuse_in ? STARTUP_LONG : STARTUP_SHORT_CYC);
	endproperty
	a_startup: assert property (p_startup) else $error("reset time-out too short");

	c_fuse: cover property ($rose(debug_enable_fuse_out));
	c_release: cover property ($fell(core_reset_out));
	c_shift: cover property ($fell(tdo_oe_n_out));
endmodule : jtag_scan_chk
bind jtag_scan_top jtag_scan_chk #(.STARTUP_LONG(STARTUP_LONG)) chk (
	.clk_in, .rstn_in, .tdo_oe_n_out, .ext_reset_n_in, .tap_enable_fuse_in,
	.tap_disable_bit_in, .clock_option_fuse_in, .lock_bit_one_in, .lock_bit_two_in,
	.fuse_program_req_in, .chip_erase_in, .debug_enable_fuse_out, .io_in,
	.io_rdata_out, .core_reset_out
);
`default_nettype wire

/* File: test/jtag_boundary_scan_data_regs_tb.sv */
// self-checking bench for the test access block and its cpu mailbox
`timescale 1ns/10ps
`default_nettype none
module jtag_boundary_scan_data_regs_tb import jtag_scan_pkg::*;;
	localparam int LONG = 100;
	localparam logic [3:0] REV = 4'h6; // arbitrary value
	localparam logic [15:0] PART = 16'h3c71; // arbitrary value
	localparam logic [10:0] MAKER = 11'h155; // arbitrary value
	logic clk_in, rstn_in, tdo_out, tdo_oe_n_out, ext_reset_n_in, tap_enable_fuse_in;
	logic tap_disable_bit_in, clock_option_fuse_in, lock_bit_one_in, lock_bit_two_in;
	logic fuse_program_req_in, chip_erase_in, debug_enable_fuse_out, mbox_ready_out;
	logic core_reset_out, oe_seen;
	logic [7:0] io_rdata_out, pin_in, pin_out, pin_oe_n_out, core_pin_out_in, core_pin_dir_in, r;
	logic [63:0] d, din;
	tap_pins_t tap_in;
	io_req_t io_in;
	int miscompares, tests_run;

	jtag_scan_top #(.STARTUP_LONG(LONG), .ID_REVISION(REV), .ID_PART(PART),
		.ID_MAKER(MAKER)) DUT (
		.clk_in, .rstn_in, .tap_in, .tdo_out, .tdo_oe_n_out, .ext_reset_n_in,
		.tap_enable_fuse_in, .tap_disable_bit_in, .clock_option_fuse_in, .lock_bit_one_in,
		.lock_bit_two_in, .fuse_program_req_in, .chip_erase_in, .debug_enable_fuse_out,
		.io_in, .io_rdata_out, .mbox_ready_out, .pin_in, .pin_out, .pin_oe_n_out,
		.core_pin_out_in, .core_pin_dir_in, .core_reset_out
	);
	jtag_host_model host (.tap_out(tap_in), .tdo_in(tdo_out));

	// 20 MHz core clock
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// remember any tdo drive, the pin is only enabled inside shifts
	always @(posedge clk_in) begin
		if (!tdo_oe_n_out) oe_seen <= 1'b1;
	end

	task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk_v

	task automatic io_wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clk_in);
		io_in <= '{a, 1'b1, 1'b0, v};
		@(posedge clk_in);
		io_in <= '0;
	endtask : io_wr

	task automatic io_rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		io_in <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge clk_in);
		io_in <= '0;
		repeat (2) @(posedge clk_in);
		#1;
		chk_v(64'(io_rdata_out), 64'(exp));
	endtask : io_rd

	// one-cycle fuse request or chip erase
	task automatic pulse(input logic erase);
		@(posedge clk_in);
		chip_erase_in <= erase;
		fuse_program_req_in <= !erase;
		@(posedge clk_in);
		chip_erase_in <= 1'b0;
		fuse_program_req_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		#1;
	endtask : pulse

	task automatic t_idcode();
		host.reset_tap();
		host.scan(1'b0, 32, 64'h0, d);
		chk_v(64'(d[31:0]), 64'({REV, PART, MAKER, 1'b1}));
	endtask : t_idcode

	task automatic t_bypass();
		host.scan(1'b1, 4, 64'(OP_BYPASS), d);
		chk_v(64'(d[3:0]), 64'(IR_CAPTURE));
		host.scan(1'b0, 8, 64'h5b, d);
		chk_v(64'(d[7:0]), 64'hb6);
	endtask : t_bypass

	// fuse off, then disable bit set: tdo must never be enabled
	task automatic t_tap_off();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_in);
			tap_enable_fuse_in <= i[0];
			tap_disable_bit_in <= i[0];
			repeat (4) @(posedge clk_in);
			oe_seen = 1'b0;
			host.scan(1'b0, 32, 64'h0, d);
			chk_v(64'(oe_seen), 64'h0);
		end
		@(posedge clk_in);
		tap_disable_bit_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		host.reset_tap();
	endtask : t_tap_off

	task automatic t_fuse();
		@(posedge clk_in);
		lock_bit_one_in <= 1'b1;
		pulse(1'b0);
		chk_v(64'(debug_enable_fuse_out), 64'h0);
		@(posedge clk_in);
		lock_bit_one_in <= 1'b0;
		lock_bit_two_in <= 1'b1;
		pulse(1'b0);
		chk_v(64'(debug_enable_fuse_out), 64'h0);
		pulse(1'b1);
		pulse(1'b0);
		chk_v(64'(debug_enable_fuse_out), 64'h1);
		@(posedge clk_in);
		lock_bit_two_in <= 1'b0;
	endtask : t_fuse

	task automatic t_mailbox();
		io_wr(MBOX_IO_ADDR, 8'h25);
		io_rd(MBOX_IO_ADDR, 8'h25);
		io_rd(6'h10, IO_UNMAPPED);
		host.scan(1'b1, 4, 64'(OP_MAILBOX), d);
		host.scan(1'b0, 10, 64'h200, d);
		io_wr(MBOX_IO_ADDR, 8'h25);
		io_rd(MBOX_IO_ADDR, 8'ha5);
		host.scan(1'b0, 10, 64'h300, d);
		chk_v(64'(d[9:0]), 64'h325);
		host.scan(1'b0, 10, 64'h200, d);
		chk_v(64'(d[8]), 64'h0);
		io_rd(MBOX_IO_ADDR, 8'h25);
		// fill to refusal, one more write is dropped
		for (int i = 0; i < 16; i++) begin
			io_wr(MBOX_IO_ADDR, 8'(i));
		end
		repeat (2) @(posedge clk_in);
		#1;
		chk_v(64'(mbox_ready_out), 64'h0);
		io_wr(MBOX_IO_ADDR, 8'hee);
		// the dropped byte must leave the stored byte and the flag alone
		io_rd(MBOX_IO_ADDR, 8'h8f);
		for (int i = 0; i < 16; i++) begin
			host.scan(1'b0, 10, 64'h300, d);
			chk_v(64'(d[7:0]), 64'(i));
		end
		io_wr(MBOX_IO_ADDR, 8'h3c);
		host.scan(1'b0, 10, 64'h300, d);
		chk_v(64'(d[9:0]), 64'h33c);
	endtask : t_mailbox

	// preload safe latches first, then drive them with extest
	task automatic t_extest();
		din = '0;
		for (int i = 0; i < 8; i++) begin
			din[3*i+1] = i[0];
			din[3*i+2] = 1'b1;
		end
		host.scan(1'b1, 4, 64'(OP_SAMPLE), d);
		host.scan(1'b0, 24, din, d);
		for (int i = 0; i < 8; i++) begin
			r[i] = d[3*i];
		end
		chk_v(64'(r), 64'h5c);
		chk_v(64'({pin_oe_n_out, pin_out & 8'h0f}), 64'hf005);
		host.scan(1'b1, 4, 64'(OP_EXTEST), d);
		chk_v(64'({pin_oe_n_out, pin_out}), 64'h00aa);
	endtask : t_extest

	task automatic t_reset();
		host.scan(1'b1, 4, 64'(OP_CORE_RESET), d);
		host.scan(1'b0, 2, 64'h1, d);
		chk_v(64'(core_reset_out), 64'h1);
		repeat (LONG + 20) @(posedge clk_in);
		#1;
		chk_v(64'(core_reset_out), 64'h0);
		host.scan(1'b0, 1, 64'h1, d);
		repeat (LONG * 2) @(posedge clk_in);
		#1;
		chk_v(64'({core_reset_out, pin_oe_n_out}), 64'h1ff);
		host.scan(1'b0, 1, 64'h0, d);
		repeat (LONG + 20) @(posedge clk_in);
		#1;
		chk_v(64'(core_reset_out), 64'h0);
		// pin reset from a running core, short time-out selected
		@(posedge clk_in);
		clock_option_fuse_in <= 1'b0;
		ext_reset_n_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		#1;
		chk_v(64'(core_reset_out), 64'h1);
		@(posedge clk_in);
		ext_reset_n_in <= 1'b1;
		repeat (LONG + 20) @(posedge clk_in);
		#1;
		chk_v(64'(core_reset_out), 64'h1);
		repeat (STARTUP_SHORT_CYC) @(posedge clk_in);
		#1;
		chk_v(64'(core_reset_out), 64'h0);
	endtask : t_reset

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	// the whole run takes well under half of this span
	initial begin
		#1_000_000;
		miscompares++;
		$display("unexpected %0t: watchdog expired", $time);
		test_done();
	end

	initial begin
		rstn_in = 1'b0;
		ext_reset_n_in = 1'b1;
		tap_enable_fuse_in = 1'b1;
		tap_disable_bit_in = 1'b0;
		clock_option_fuse_in = 1'b1;
		lock_bit_one_in = 1'b0;
		lock_bit_two_in = 1'b0;
		fuse_program_req_in = 1'b0;
		chip_erase_in = 1'b0;
		io_in = '0;
		pin_in = 8'h5c;
		core_pin_out_in = 8'h05;
		core_pin_dir_in = 8'h0f;
		oe_seen = 1'b0;
		miscompares = 0;
		tests_run = 0;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (LONG + 20) @(posedge clk_in);
		t_idcode();
		t_bypass();
		t_tap_off();
		t_fuse();
		t_mailbox();
		t_extest();
		t_reset();
		test_done();
	end
endmodule : jtag_boundary_scan_data_regs_tb
`default_nettype wire
